// ==== adccs_defines.svh ====
`ifndef ADCCS_DEFINES_SVH
`define ADCCS_DEFINES_SVH

// System clock
`define ADCCS_CLK_MHZ 20

// Power-on reset pulse
`define ADCCS_POR_US 1000
`define ADCCS_POR_CYC (`ADCCS_POR_US * `ADCCS_CLK_MHZ)

// Conversion length on the internal oscillator, per notch choice
`define ADCCS_CONV50_US 20000
`define ADCCS_CONV60_US 16667
`define ADCCS_CONV50_CYC (`ADCCS_CONV50_US * `ADCCS_CLK_MHZ)
`define ADCCS_CONV60_CYC (`ADCCS_CONV60_US * `ADCCS_CLK_MHZ)

// External clock periods per conversion, sets the first null
`define ADCCS_NULL_DIV 2560

// Calibration slot at the head of each conversion
`define ADCCS_CAL_US 4
`define ADCCS_CAL_CYC (`ADCCS_CAL_US * `ADCCS_CLK_MHZ)

// Internal serial clock, half period rounded down
`define ADCCS_ISCK_HZ 19200
`define ADCCS_ISCK_HALF_CYC ((`ADCCS_CLK_MHZ * 1000000) / (2 * `ADCCS_ISCK_HZ))

// Silence on the frequency pin that means no external clock
`define ADCCS_EXT_DET_US 20
`define ADCCS_EXT_DET_CYC (`ADCCS_EXT_DET_US * `ADCCS_CLK_MHZ)

// Output word
`define ADCCS_WORD_BITS 32
`define ADCCS_LAST_BIT 31
`define ADCCS_FIFO_DEPTH 8

`endif

// ==== adccs_pkg.sv ====
package adccs_pkg;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_CONV,
    ST_SLEEP,
    ST_OUT
  } adccs_state_t;

  typedef struct packed {
    logic        result_sign_bit;
    logic [23:0] value;
    logic [4:0]  sub_lsb;
  } adccs_result_t;

  typedef struct packed {
    logic out;
    logic oe;
  } adccs_pin_t;

endpackage

// ==== adccs_core.sv ====
`timescale 1ns/1ps
`include "adccs_defines.svh"

module adccs_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = `ADCCS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = wr_ptr + 1'b1;
    end
    if (pop)
      next_rd_ptr = rd_ptr + 1'b1;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    mem <= next_mem;
    if (srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule

// Summary of operation
// RULE_01: Cycle forever through conversion, sleep, then data output.
// RULE_02: After conversion sleep while chip select high; hold result unchanged.
// RULE_03: Chip select low enables data output and wakes for readout.
// RULE_04: Chip select rising during output aborts and starts a conversion.
// RULE_05: Data output is high impedance whenever chip select is high.
// RULE_06: With chip select low in conversion or sleep, output shows status.
// RULE_07: Internal mode drives serial clock; external mode controller drives it.
// RULE_08: Clock mode sampled at power-up and chip select fall; pull-up internal.
// RULE_09: Frequency pin high gives 50Hz null, low gives 60Hz null.
// RULE_10: Clock on frequency pin becomes system clock; null is f/2560.
// RULE_11: Data changes on serial clock fall; controller samples on rise.
// RULE_12: Output ends after 32 bits or chip select high; converts again.
// RULE_13: Each readout carries the preceding conversion, one word each.
// RULE_14: Modes come only from pin timing; no configuration registers.
// RULE_15: Offset and full-scale calibration run inside every conversion.
// RULE_16: Low supply holds internal reset, keeping result and clock mode.
// RULE_17: Leaving low supply gives 1ms reset clearing registers, then convert.
// RULE_18: Word is MSB first: done low, zero, sign, 24 bits, 5 sub bits.
// RULE_19: The 32nd falling clock edge drives output high as next done.
// RULE_20: With chip select high, outside clock pulses leave shifter untouched.
// RULE_21: Conversion lasts a set cycle count, then loads result, done low.
// RULE_22: Internal serial clock divides system clock; stops after last bit.
module adccs_core #(
  parameter int POR_CYCLES = `ADCCS_POR_CYC,
  parameter int CONV50_CYC = `ADCCS_CONV50_CYC,
  parameter int CONV60_CYC = `ADCCS_CONV60_CYC
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // Serial port
  input  wire logic                   cs_n,
  input  wire logic                   sck_in,
  output logic                        sck_out,
  output logic                        sck_oe,
  output logic                        sck_pullup_en,
  output logic                        sdo_out,
  output logic                        sdo_oe,
  // Frequency control
  input  wire logic                   notch_select_clock_in,
  output logic                        ext_osc_active,
  output logic                        notch_50hz,
  // Supply monitor
  input  wire logic                   supply_low,
  output logic                        por_active,
  // Result stream from the modulator
  input  wire logic                   res_valid,
  output logic                        res_ready,
  input  wire adccs_pkg::adccs_result_t res_data,
  // Status
  output adccs_pkg::adccs_state_t     conv_state,
  output logic                        cal_active
);
  localparam int HALF = `ADCCS_ISCK_HALF_CYC;
  localparam int DET  = `ADCCS_EXT_DET_CYC;

  adccs_pkg::adccs_state_t  state;
  adccs_pkg::adccs_state_t  next_state;
  adccs_pkg::adccs_result_t fifo_data;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [19:0] conv_cnt;
  logic [19:0] next_conv_cnt;
  logic [14:0] por_cnt;
  logic [14:0] next_por_cnt;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [9:0]  div_cnt;
  logic [9:0]  next_div_cnt;
  logic [8:0]  det_cnt;
  logic [8:0]  next_det_cnt;
  logic        sck_lvl;
  logic        next_sck_lvl;
  logic        int_mode;
  logic        next_int_mode;
  logic        cs_q;
  logic        sck_q;
  logic        notch_q;
  logic        fifo_valid;
  logic        pop;
  logic        fall;
  logic        conv_done;
  logic        tick;

  adccs_fifo #(
    .WIDTH ($bits(adccs_pkg::adccs_result_t)),
    .DEPTH (`ADCCS_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   (res_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // Edges on the frequency pin mean an external system clock
  assign ext_osc_active = det_cnt < 9'(DET); // RULE_10
  assign notch_50hz     = !ext_osc_active && notch_select_clock_in; // RULE_09
  // External clock: conversion advances once per pin period
  assign tick = ext_osc_active ? (notch_select_clock_in && !notch_q) : 1'b1;
  // At or past the end, so a notch change mid-count cannot run it away
  always_comb
  begin
    if (ext_osc_active)
      conv_done = conv_cnt >= 20'(`ADCCS_NULL_DIV - 1); // RULE_10
    else if (notch_select_clock_in)
      conv_done = conv_cnt >= 20'(CONV50_CYC - 1); // RULE_09
    else
      conv_done = conv_cnt >= 20'(CONV60_CYC - 1); // RULE_09
  end

  // Calibration shares the conversion slot, so cycle order never changes
  assign cal_active = state == adccs_pkg::ST_CONV &&
                      conv_cnt < 20'(`ADCCS_CAL_CYC); // RULE_15

  // Falling serial clock: divider in internal mode, pin otherwise
  assign fall = state == adccs_pkg::ST_OUT && !cs_n && // RULE_20
                !supply_low && // RULE_16
                (int_mode ? (sck_lvl && div_cnt == 10'(HALF - 1))
                          : (sck_q && !sck_in)); // RULE_11
  assign pop  = state == adccs_pkg::ST_CONV && conv_done && tick &&
                fifo_valid && !supply_low;

  always_comb
  begin
    next_state    = state;
    next_shreg    = shreg;
    next_conv_cnt = conv_cnt;
    next_por_cnt  = por_cnt;
    next_bit_cnt  = bit_cnt;
    next_div_cnt  = div_cnt;
    next_sck_lvl  = sck_lvl;
    next_int_mode = int_mode;
    next_det_cnt  = det_cnt;
    if (notch_select_clock_in != notch_q)
      next_det_cnt = '0;
    else if (det_cnt != 9'h1ff)
      next_det_cnt = det_cnt + 1'b1;
    // Mode set only by pin levels, never by a register
    if (cs_q && !cs_n && state != adccs_pkg::ST_RESET && !supply_low)
      next_int_mode = sck_in; // RULE_08 RULE_14
    case (state)
      adccs_pkg::ST_RESET:
      begin
        if (!supply_low)
        begin
          next_por_cnt = por_cnt + 1'b1;
          if (por_cnt == 15'(POR_CYCLES - 1))
          begin
            // Clear only at pulse end; low supply alone keeps state
            next_shreg    = '0; // RULE_17
            next_int_mode = sck_in; // RULE_08
            next_conv_cnt = '0;
            next_state    = adccs_pkg::ST_CONV; // RULE_17
          end
        end
        else
          next_por_cnt = '0; // RULE_16
      end
      adccs_pkg::ST_CONV:
      begin
        if (pop)
        begin
          next_shreg = {1'b0, 1'b0, fifo_data}; // RULE_13 RULE_18 RULE_21
          next_state = adccs_pkg::ST_SLEEP; // RULE_01
        end
        else if (tick && !conv_done)
          next_conv_cnt = conv_cnt + 1'b1; // RULE_21
      end
      adccs_pkg::ST_SLEEP:
      begin
        // Static hold for as long as chip select stays high
        if (!cs_n) // RULE_02
        begin
          next_state   = adccs_pkg::ST_OUT; // RULE_03
          next_bit_cnt = '0;
          next_div_cnt = '0;
          next_sck_lvl = 1'b0;
        end
      end
      adccs_pkg::ST_OUT:
      begin
        if (cs_n)
        begin
          next_state    = adccs_pkg::ST_CONV; // RULE_04 RULE_12
          next_conv_cnt = '0;
        end
        else
        begin
          if (int_mode)
          begin
            next_div_cnt = div_cnt + 1'b1;
            if (div_cnt == 10'(HALF - 1))
            begin
              next_div_cnt = '0;
              next_sck_lvl = !sck_lvl; // RULE_22
            end
          end
          if (fall)
          begin
            next_shreg   = {shreg[30:0], 1'b1}; // RULE_11 RULE_19
            next_bit_cnt = bit_cnt + 1'b1;
            if (bit_cnt == 5'(`ADCCS_LAST_BIT))
            begin
              next_state    = adccs_pkg::ST_CONV; // RULE_12 RULE_22
              next_conv_cnt = '0;
              next_sck_lvl  = 1'b0;
            end
          end
        end
      end
      default: next_state = adccs_pkg::ST_RESET;
    endcase
    if (supply_low)
    begin
      next_state   = adccs_pkg::ST_RESET; // RULE_16
      next_por_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state    <= adccs_pkg::ST_RESET;
      shreg    <= '0;
      conv_cnt <= '0;
      por_cnt  <= '0;
      bit_cnt  <= '0;
      div_cnt  <= '0;
      det_cnt  <= 9'h1ff;
      sck_lvl  <= 1'b0;
      int_mode <= 1'b1;
      cs_q     <= 1'b1;
      sck_q    <= 1'b1;
      // Pin level taken here, so no false edge follows reset
      notch_q  <= notch_select_clock_in;
    end
    else
    begin
      state    <= next_state;
      shreg    <= next_shreg;
      conv_cnt <= next_conv_cnt;
      por_cnt  <= next_por_cnt;
      bit_cnt  <= next_bit_cnt;
      div_cnt  <= next_div_cnt;
      det_cnt  <= next_det_cnt;
      sck_lvl  <= next_sck_lvl;
      int_mode <= next_int_mode;
      cs_q     <= cs_n;
      sck_q    <= sck_in;
      notch_q  <= notch_select_clock_in;
    end
  end

  assign conv_state    = state;
  assign por_active    = state == adccs_pkg::ST_RESET;
  assign sck_pullup_en = int_mode; // RULE_08
  assign sck_oe  = int_mode && state == adccs_pkg::ST_OUT; // RULE_07
  assign sck_out = sck_lvl;
  assign sdo_oe  = !cs_n; // RULE_03 RULE_05
  // Busy reads high; the loaded word starts with done low
  assign sdo_out = state == adccs_pkg::ST_CONV ||
                   state == adccs_pkg::ST_RESET || shreg[31]; // RULE_06

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_last_fall;
    state == adccs_pkg::ST_OUT && fall && bit_cnt == 5'd31;
  endsequence

  sequence s_sleep_twice;
    state == adccs_pkg::ST_SLEEP ##1 state == adccs_pkg::ST_SLEEP;
  endsequence

  a_sdo_hiz_cs: assert property (cs_n |-> !sdo_oe) // RULE_05
    else $error("data output enabled with chip select high");
  a_conv_status: assert property (
    state == adccs_pkg::ST_CONV && !cs_n |-> sdo_oe && sdo_out) // RULE_06
    else $error("busy status not shown");
  a_sleep_hold: assert property (s_sleep_twice |-> $stable(shreg)) // RULE_02
    else $error("result changed while asleep");
  a_wake_out: assert property (
    state == adccs_pkg::ST_SLEEP && !cs_n && !supply_low
    |=> state == adccs_pkg::ST_OUT) // RULE_03
    else $error("no wake on chip select low");
  a_cs_abort: assert property (
    state == adccs_pkg::ST_OUT && cs_n && !supply_low
    |=> state == adccs_pkg::ST_CONV && conv_cnt == '0) // RULE_04
    else $error("abort did not restart conversion");
  a_last_bit: assert property (
    s_last_fall and (!supply_low)
    |=> state == adccs_pkg::ST_CONV ##0 sdo_out ##0 shreg[31]) // RULE_19
    else $error("32nd fall did not end output high");
  a_word_load: assert property (
    pop |=> shreg == {2'b00, $past(fifo_data)}
        ##0 state == adccs_pkg::ST_SLEEP) // RULE_13
    else $error("result word not loaded");
  a_isck_drive: assert property ( // RULE_22
    sck_oe && !cs_n && !supply_low && div_cnt == 10'(HALF - 1)
    |=> sck_out != $past(sck_out))
    else $error("internal clock missed its half period");
  a_mode_sample: assert property (
    cs_q && !cs_n && state != adccs_pkg::ST_RESET && !supply_low
    |=> int_mode == $past(sck_in)) // RULE_08
    else $error("clock mode not sampled on select fall");
  a_cycle_order: assert property (
    $rose(state == adccs_pkg::ST_SLEEP)
    |-> $past(state) == adccs_pkg::ST_CONV) // RULE_01
    else $error("sleep entered out of order");
  a_supply_hold: assert property (
    supply_low |=> state == adccs_pkg::ST_RESET && $stable(int_mode)
                   && $stable(shreg)) // RULE_16
    else $error("low supply did not hold state");
endmodule

// ==== adccs_ctrl_model.sv ====
`timescale 1ns/1ps
module adccs_ctrl_model (
  // Clock
  input  wire logic   sys_clk,
  // Serial pins
  input  wire logic   sdo_out,
  input  wire logic   sck_pin,
  output logic        cs_n,
  output logic        m_sck,
  output logic        m_oe,
  // Captured word
  output logic        rd_done,
  output logic [31:0] rd_word,
  output logic [5:0]  rd_bits,
  output logic        tmo
);
  initial
  begin
    cs_n = 1'b1;
    m_sck = 1'b0;
    m_oe = 1'b1;
    rd_done = 1'b0;
    rd_word = 32'h0;
    rd_bits = 6'h0;
    tmo = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Pulses with select high; the shifter must not move
  task automatic wiggle(input int n);
    repeat (n)
    begin
      m_sck = ~m_sck;
      step(2);
    end
    m_sck = 1'b0;
    step(1);
  endtask

  // Clock level at select fall picks the clock source
  task automatic read(input bit int_mode, input int nbits);
    int   k;
    int   t;
    logic last;
    m_sck = int_mode;
    step(1);
    cs_n = 1'b0;
    step(2);
    m_oe = !int_mode;
    rd_word = 32'h0;
    k = 0;
    t = 0;
    while (sdo_out !== 1'b0 && t < 5000)
    begin
      step(1);
      t++;
    end
    last = sck_pin;
    while (k < nbits && t < 40000)
    begin
      if (int_mode)
      begin
        if (sck_pin && !last)
        begin
          rd_word[31-k] = sdo_out;
          k++;
        end
        last = sck_pin;
        step(1);
      end
      else
      begin
        rd_word[31-k] = sdo_out;
        m_sck = 1'b1;
        step(2);
        m_sck = 1'b0;
        step(3);
        k++;
      end
      t++;
    end
    // Last internal fall comes a half period after the last rise
    if (int_mode)
      step(600);
    tmo = (k < nbits);
    rd_bits = 6'(k);
    rd_done = 1'b1;
    step(1);
    rd_done = 1'b0;
  endtask

  task automatic finish_read();
    cs_n = 1'b1;
    m_oe = 1'b1;
    step(1);
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  // Design pins
  logic                     sys_clk, srst, sck_in, sck_out, sck_oe;
  logic                     sck_pullup_en, sdo_out, sdo_oe, notch_pin;
  logic                     ext_osc_active, notch_50hz, supply_low;
  logic                     por_active, res_valid, res_ready, cal_active;
  adccs_pkg::adccs_result_t res_data;
  adccs_pkg::adccs_state_t  conv_state;
  // Controller side
  logic                     cs_n, m_sck, m_oe, rd_done, tmo;
  logic [31:0]              rd_word;
  logic [5:0]               rd_bits;
  logic [31:0]              exp_q[$];
  int                       fail_count;
  int                       compares;
  logic                     sdo_pin;
  localparam int            CONV50 = 200;
  localparam int            CONV60 = 150;

  // Pull-up holds the clock pin high when nobody drives it
  assign sck_in = m_oe ? m_sck : (sck_oe ? sck_out : sck_pullup_en);
  // Released data line shows the inverse, so a late enable is caught
  assign sdo_pin = sdo_oe ? sdo_out : ~sdo_out;

  adccs_core #(.POR_CYCLES(8), .CONV50_CYC(CONV50), .CONV60_CYC(CONV60)) dut (
    .sys_clk, .srst, .cs_n, .sck_in, .sck_out, .sck_oe, .sck_pullup_en,
    .sdo_out, .sdo_oe, .notch_select_clock_in(notch_pin), .ext_osc_active,
    .notch_50hz, .supply_low, .por_active, .res_valid, .res_ready,
    .res_data, .conv_state, .cal_active);

  adccs_ctrl_model ctrl (
    .sys_clk, .sdo_out(sdo_pin), .sck_pin(sck_in), .cs_n, .m_sck, .m_oe,
    .rd_done, .rd_word, .rd_bits, .tmo);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string s);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, exp, input int n);
    logic [31:0] mask;
    mask = 32'hffffffff << (32 - n);
    compares++;
    if ((got & mask) !== (exp & mask))
    begin
      fail_count++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d failures %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic lost(input string s);
    fail_count++;
    $display("[FAIL] %0t %s", $time, s);
    results();
  endtask

  task automatic wait_state(input adccs_pkg::adccs_state_t s);
    int t;
    t = 0;
    while (conv_state !== s && t < 2000)
    begin
      step(1);
      t++;
    end
    if (t >= 2000)
      lost("state wait timed out");
  endtask

  task automatic push(input logic [29:0] v);
    int t;
    t = 0;
    res_data = v;
    res_valid = 1'b1;
    while (res_ready !== 1'b1 && t < 2000)
    begin
      step(1);
      t++;
    end
    if (t >= 2000)
      lost("stream stalled");
    step(1);
    res_valid = 1'b0;
    exp_q.push_back({2'b00, v});
    step(1);
  endtask

  task automatic conv_len(input int n);
    int t;
    t = 0;
    while (conv_state !== adccs_pkg::ST_SLEEP && t < 2000)
    begin
      step(1);
      t++;
    end
    chk_bit(t == n, 1'b1, "conversion length");
  endtask

  // External clock on the frequency pin paces the conversion
  task automatic notch_pulse(input int n);
    repeat (n)
    begin
      notch_pin = 1'b1;
      step(2);
      notch_pin = 1'b0;
      step(2);
    end
  endtask

  task automatic readout(input bit int_mode, input int n);
    ctrl.read(int_mode, n);
    chk_bit(sdo_oe, 1'b1, "sdo enable");
    if (n == 32)
      chk_bit(sdo_out, 1'b1, "flag after word");
    ctrl.finish_read();
    chk_bit(sdo_oe, 1'b0, "sdo release");
    chk_bit(conv_state === adccs_pkg::ST_CONV, 1'b1, "new conv");
  endtask

  always @(posedge sys_clk)
  begin
    if (rd_done)
    begin
      if (tmo || exp_q.size() == 0)
        lost("readout lost");
      else
        chk_word(rd_word, exp_q.pop_front(), int'(rd_bits));
    end
  end

  initial
  begin
    srst = 1'b1;
    supply_low = 1'b0;
    notch_pin = 1'b1;
    res_valid = 1'b0;
    res_data = 30'h0;
    fail_count = 0;
    compares = 0;
    void'($urandom(93867));
    step(2);
    srst = 1'b0;
    chk_bit(por_active, 1'b1, "por pulse");
    chk_bit(sck_pullup_en, 1'b1, "pull-up at reset");
    step(5);
    chk_bit(conv_state === adccs_pkg::ST_RESET, 1'b1, "por length");
    step(5);
    chk_bit(conv_state === adccs_pkg::ST_CONV, 1'b1, "first conv");
    chk_bit(cal_active, 1'b1, "calibration slot");
    $display("test reset done");
    push(30'h0);
    push(30'h3fffffff);
    push(30'($urandom));
    wait_state(adccs_pkg::ST_SLEEP);
    ctrl.wiggle(20);
    chk_bit(conv_state === adccs_pkg::ST_SLEEP, 1'b1, "sleep held");
    chk_bit(sdo_oe, 1'b0, "sdo idle");
    repeat (3) readout(1'b0, 32);
    $display("test external readout done");
    push(30'($urandom));
    push(30'($urandom));
    readout(1'b0, 5);
    conv_len(CONV50);
    readout(1'b0, 32);
    $display("test abort done");
    // One word goes to the waiting conversion, eight fill the buffer
    repeat (9) push(30'($urandom));
    step(300);
    chk_bit(res_ready, 1'b0, "buffer full");
    res_valid = 1'b1;
    step(4);
    chk_bit(res_ready, 1'b0, "refused while full");
    res_valid = 1'b0;
    repeat (9) readout(1'b0, 32);
    chk_bit(res_ready, 1'b1, "buffer drained");
    $display("test buffer done");
    push(30'($urandom));
    readout(1'b1, 32);
    chk_bit(sck_pullup_en, 1'b1, "pull-up internal");
    push(30'($urandom));
    readout(1'b0, 32);
    chk_bit(sck_pullup_en, 1'b0, "pull-up external");
    $display("test clock modes done");
    notch_pin = 1'b0;
    step(450);
    chk_bit(ext_osc_active, 1'b0, "internal osc");
    chk_bit(notch_50hz, 1'b0, "60 Hz notch");
    supply_low = 1'b1;
    step(2);
    chk_bit(conv_state === adccs_pkg::ST_RESET, 1'b1, "low supply");
    push(30'($urandom));
    supply_low = 1'b0;
    wait_state(adccs_pkg::ST_CONV);
    conv_len(CONV60);
    readout(1'b0, 32);
    $display("test supply done");
    push(30'($urandom));
    notch_pulse(2500);
    chk_bit(conv_state === adccs_pkg::ST_CONV, 1'b1, "ext busy");
    notch_pulse(100);
    chk_bit(ext_osc_active, 1'b1, "external clock seen");
    chk_bit(conv_state === adccs_pkg::ST_SLEEP, 1'b1, "ext done");
    readout(1'b0, 32);
    notch_pin = 1'b1;
    step(500);
    chk_bit(ext_osc_active, 1'b0, "external clock gone");
    chk_bit(notch_50hz, 1'b1, "50 Hz notch");
    chk_bit(exp_q.size() == 0, 1'b1, "words left over");
    $display("test frequency pin done");
    results();
  end
endmodule
